// [core/wwdt_pkg.sv]
// package: constants, types and register map of the window watchdog
`default_nettype none
package wwdt_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [7:0] US_CYC = 8'(1000 / CLK_PERIOD_NS); // cycles per microsecond
  localparam int STARTUP_DELAY_S = 10;
  localparam int OPEN_MAX_S = 640;
  localparam logic [39:0] CYC_PER_S = 40'(CLK_MHZ) * 40'h0F4240;
  localparam logic [39:0] STARTUP_CYC_DEF = 40'(STARTUP_DELAY_S) * CYC_PER_S;
  localparam logic [39:0] OPEN_MAX_CYC_DEF = 40'(OPEN_MAX_S) * CYC_PER_S;

  // ==========================================================
  // close window from sensed capacitance, counted in units of 10 pF
  localparam int CAP_UNIT_PF = 10;
  // cycles per unit for each tenth of the per-farad factor (times ten to the sixth)
  localparam logic [7:0] CAP_CYC_PER_TENTH = 8'(CAP_UNIT_PF * CLK_MHZ / 10);
  localparam logic [9:0] CAP_F_SLOW = 10'h318; // 79.2
  localparam logic [9:0] CAP_F_MID = 10'h18C;  // 39.6
  localparam logic [9:0] CAP_F_FAST = 10'h063; // 9.9
  localparam logic [31:0] CAP_MAX_UNITS = 32'h0001_86A0;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CLOSE = 8'h04;
  localparam logic [7:0] ADDR_RATIO = 8'h08;
  localparam logic [7:0] ADDR_CAP = 8'h0C;
  localparam logic [7:0] ADDR_HOLD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // variant configuration word
  typedef struct packed {
    logic startup_en; // 10 s startup delay instead of none
    logic cap_mode;   // close window from capacitance
    logic sep_fault;  // separate fault output pin
    logic two_sel;    // two ratio-select pins
    logic has_en;     // dedicated enable pin
  } wwdt_cfg_t;
  localparam int CFG_W = 5;
  localparam wwdt_cfg_t CFG_RST = '{startup_en: 1'h1, cap_mode: 1'h0, sep_fault: 1'h1,
                                    two_sel: 1'h1, has_en: 1'h1};

  localparam logic [31:0] CLOSE_US_RST = 32'h0000_2710;
  localparam logic [31:0] HOLD_US_RST = 32'h0003_0D40;
  localparam logic [31:0] CAP_RST = 32'h0000_0000;
  localparam int RATIO_W = 9;
  localparam int RATIO_FIELDS_W = 27;
  localparam logic [26:0] RATIO_RST = 27'h07C_0E03;

  // status word fields
  localparam int ST_EN_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_FLAGS_LSB = 8;

  typedef struct packed {
    logic sd_err;
    logic late;
    logic early;
  } wwdt_flags_t;

  // ==========================================================
  // pins, select codes, bus fields
  localparam int PIN_SVC = 0;
  localparam int PIN_EN = 1;
  localparam int PIN_SEL_LO = 2;
  localparam int PIN_SEL_HI = 3;
  localparam int PIN_SUP = 4;
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_SYNC_RST = 5'h01;
  localparam logic [1:0] SEL_DISABLE = 2'h1;
  localparam logic [1:0] SEL_MID = 2'h2;
  localparam logic [1:0] SEL_FAST = 2'h3;
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [2:0] {
    PH_SUPRST,
    PH_IDLE,
    PH_STARTUP,
    PH_CLOSE,
    PH_OPEN,
    PH_FAULT
  } wwdt_phase_t;

endpackage
`default_nettype wire

// [core/wwdt_core.sv]
// window watchdog timer with an ahb-lite register slave
`default_nettype none

module wwdt_core #(
  parameter logic [39:0] STARTUP_CYC = wwdt_pkg::STARTUP_CYC_DEF,
  parameter logic [39:0] OPEN_MAX_CYC = wwdt_pkg::OPEN_MAX_CYC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic service_input,
  input wire logic guard_enable_pin,
  input wire logic ratio_select_low,
  input wire logic ratio_select_high,
  input wire logic supervisor_reset_n,
  output logic watchdog_fault_output_n,
  output logic reset_output_n
);
  import wwdt_pkg::*;

  // ==========================================================
  // decode helpers

  // select code to ratio slot: 00 and 01 share the first slot
  function automatic logic [1:0] ratio_index(input logic [1:0] code);
    logic [1:0] idx;
    idx = 2'h0;
    if (code == SEL_MID) begin
      idx = 2'h1;
    end else if (code == SEL_FAST) begin
      idx = 2'h2;
    end
    return idx;
  endfunction

  // per-farad factor, in tenths, for the capacitor-timed close window
  function automatic logic [9:0] cap_factor(input logic [1:0] idx);
    logic [9:0] f;
    f = CAP_F_SLOW;
    if (idx == 2'h1) begin
      f = CAP_F_MID;
    end else if (idx == 2'h2) begin
      f = CAP_F_FAST;
    end
    return f;
  endfunction

  // ==========================================================
  // state declarations
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic svc_prev_ff;

  wwdt_cfg_t cfg_ff, nxt_cfg;
  logic [31:0] close_us_ff, nxt_close_us;
  logic [RATIO_FIELDS_W-1:0] ratio_ff, nxt_ratio;
  logic [31:0] cap_reg_ff, nxt_cap_reg;
  logic [31:0] hold_us_ff, nxt_hold_us;
  wwdt_flags_t flags_ff, nxt_flags;
  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;

  wwdt_phase_t state_ff, nxt_state;
  logic [39:0] cnt_ff, nxt_cnt;
  logic [1:0] applied_ff, nxt_applied;
  logic [31:0] cap_act_ff, nxt_cap_act;
  logic fault_n_ff, nxt_fault_n;
  logic reset_n_ff, nxt_reset_n;

  // ==========================================================
  // pin synchronisers
  assign pins_raw = {supervisor_reset_n, ratio_select_high, ratio_select_low, guard_enable_pin, service_input};

  // two flops per pin; the edge flop looks only at the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= PIN_SYNC_RST;
      sync2_ff <= PIN_SYNC_RST;
      svc_prev_ff <= 1'h1;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      svc_prev_ff <= sync2_ff[PIN_SVC];
    end
  end

  // ==========================================================
  // live decode of pins and configuration
  logic svc_fall;
  logic sup_ok;
  logic [1:0] sel_code;
  logic [1:0] live_idx;
  logic pin_disable;
  logic cap_ok;
  logic live_en;

  assign svc_fall = svc_prev_ff & ~sync2_ff[PIN_SVC];
  assign sup_ok = sync2_ff[PIN_SUP];
  // one pin maps to codes 00 and 10 so both variants share the ratio slots
  assign sel_code = cfg_ff.two_sel ? {sync2_ff[PIN_SEL_HI], sync2_ff[PIN_SEL_LO]}
                                   : {sync2_ff[PIN_SEL_LO], 1'h0};
  assign live_idx = ratio_index(sel_code);
  assign pin_disable = cfg_ff.two_sel & ~cfg_ff.has_en & (sel_code == SEL_DISABLE);
  // grounded or oversized capacitor, only meaningful in capacitor mode
  assign cap_ok = ~cfg_ff.cap_mode | ((cap_act_ff != '0) & (cap_act_ff <= CAP_MAX_UNITS));
  assign live_en = sup_ok & cap_ok & (cfg_ff.has_en ? sync2_ff[PIN_EN] : ~pin_disable);

  // ==========================================================
  // window lengths in cycles, from the ratio slot in force
  logic [RATIO_W-1:0] ratio_n;
  logic [RATIO_W-1:0] n_minus;
  logic [63:0] close_prod;
  logic [63:0] open_prod;
  logic [63:0] hold_prod;
  logic [39:0] close_cyc;
  logic [39:0] open_cyc;
  logic [39:0] hold_cyc;
  logic [39:0] term;
  logic done;

  assign ratio_n = ratio_ff[applied_ff * RATIO_W +: RATIO_W];
  // a ratio of zero is treated as one, giving an empty open window
  assign n_minus = (ratio_n != '0) ? ratio_n - 9'h001 : '0;
  assign close_prod = cfg_ff.cap_mode
    ? 64'(cap_act_ff) * 64'(cap_factor(applied_ff)) * 64'(CAP_CYC_PER_TENTH)
    : 64'(close_us_ff) * 64'(US_CYC);
  assign close_cyc = close_prod[39:0];
  assign open_prod = 64'(n_minus) * 64'(close_cyc);
  assign open_cyc = (open_prod > 64'(OPEN_MAX_CYC)) ? OPEN_MAX_CYC : open_prod[39:0];
  assign hold_prod = 64'(hold_us_ff) * 64'(US_CYC);
  assign hold_cyc = hold_prod[39:0];

  // terminal count for the phase in progress
  always_comb begin
    term = '0;
    unique case (state_ff)
      PH_STARTUP: term = STARTUP_CYC;
      PH_CLOSE: term = close_cyc;
      PH_OPEN: term = open_cyc;
      PH_FAULT: term = hold_cyc;
      default: term = '0;
    endcase
  end
  assign done = ({1'h0, cnt_ff} + 41'h1) >= {1'h0, term};

  // ==========================================================
  // watchdog sequencer
  logic restart;
  wwdt_flags_t ev;
  logic go_fault;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 40'h1;
    nxt_applied = applied_ff;
    nxt_cap_act = cap_act_ff;
    restart = 1'h0;
    ev = '0;
    if (!sup_ok) begin
      // supervisor reset wins over everything, fault pin released
      nxt_state = PH_SUPRST;
      restart = 1'h1;
    end else if (state_ff == PH_SUPRST) begin
      // capacitor is sensed once here and never on the fly
      nxt_cap_act = cap_reg_ff;
      nxt_state = cfg_ff.startup_en ? PH_STARTUP : PH_CLOSE;
      restart = 1'h1;
    end else if (!live_en) begin
      nxt_state = PH_IDLE;
      restart = 1'h1;
    end else begin
      unique case (state_ff)
        PH_IDLE: begin
          nxt_state = PH_CLOSE;
          restart = 1'h1;
        end
        PH_STARTUP: begin
          if (svc_fall) begin
            nxt_state = PH_CLOSE;
            restart = 1'h1;
          end else if (done) begin
            nxt_state = PH_FAULT;
            ev.sd_err = 1'h1;
            restart = 1'h1;
          end
        end
        PH_CLOSE: begin
          if (live_idx != applied_ff) begin
            restart = 1'h1;
          end else if (svc_fall) begin
            nxt_state = PH_FAULT;
            ev.early = 1'h1;
            restart = 1'h1;
          end else if (done) begin
            nxt_state = PH_OPEN;
            restart = 1'h1;
          end
        end
        PH_OPEN: begin
          if (live_idx != applied_ff) begin
            nxt_state = PH_CLOSE;
            restart = 1'h1;
          end else if (svc_fall) begin
            nxt_state = PH_CLOSE;
            restart = 1'h1;
          end else if (done) begin
            nxt_state = PH_FAULT;
            ev.late = 1'h1;
            restart = 1'h1;
          end
        end
        PH_FAULT: begin
          // select changes seen during the fault wait for the next close window
          if (done) begin
            nxt_state = cfg_ff.startup_en ? PH_STARTUP : PH_CLOSE;
            restart = 1'h1;
          end
        end
        default: begin
          nxt_state = PH_SUPRST;
          restart = 1'h1;
        end
      endcase
    end
    if (restart) begin
      nxt_cnt = '0;
    end
    // the ratio slot is taken over only when a close window starts or runs
    if (nxt_state == PH_CLOSE) begin
      nxt_applied = live_idx;
    end
  end

  // outputs computed from the next phase so they leave a flop directly
  assign go_fault = (nxt_state == PH_FAULT);
  assign nxt_fault_n = ~(go_fault & cfg_ff.sep_fault);
  assign nxt_reset_n = sup_ok & (cfg_ff.sep_fault | ~go_fault);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= PH_SUPRST;
      cnt_ff <= '0;
      applied_ff <= 2'h0;
      cap_act_ff <= CAP_RST;
      fault_n_ff <= 1'h1;
      reset_n_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      applied_ff <= nxt_applied;
      cap_act_ff <= nxt_cap_act;
      fault_n_ff <= nxt_fault_n;
      reset_n_ff <= nxt_reset_n;
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  logic accept;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_val;
  logic [31:0] status_val;
  wwdt_flags_t flag_clr;

  assign accept = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
  assign rd_addr = haddr[ADDR_W-1:0];

  // live status word: enable, outputs, phase and sticky fault causes
  always_comb begin
    status_val = '0;
    status_val[ST_EN_BIT] = live_en;
    status_val[ST_FAULT_BIT] = ~fault_n_ff;
    status_val[ST_RESET_BIT] = ~reset_n_ff;
    status_val[ST_PHASE_LSB +: 3] = state_ff;
    status_val[ST_FLAGS_LSB +: 3] = flags_ff;
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_val = '0;
    unique case (rd_addr)
      ADDR_CONFIG: rd_val[CFG_W-1:0] = cfg_ff;
      ADDR_CLOSE: rd_val = close_us_ff;
      ADDR_RATIO: rd_val[RATIO_FIELDS_W-1:0] = ratio_ff;
      ADDR_CAP: rd_val = cap_reg_ff;
      ADDR_HOLD: rd_val = hold_us_ff;
      ADDR_STATUS: rd_val = status_val;
      default: rd_val = '0;
    endcase
  end

  // address phase is latched, writes land in the data phase
  always_comb begin
    nxt_wr_pend = accept & hwrite;
    nxt_wr_addr = accept ? rd_addr : wr_addr_ff;
    nxt_hrdata = (accept & ~hwrite) ? rd_val : hrdata_ff;
    nxt_cfg = cfg_ff;
    nxt_close_us = close_us_ff;
    nxt_ratio = ratio_ff;
    nxt_cap_reg = cap_reg_ff;
    nxt_hold_us = hold_us_ff;
    flag_clr = '0;
    if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        ADDR_CONFIG: nxt_cfg = wwdt_cfg_t'(hwdata[CFG_W-1:0]);
        ADDR_CLOSE: nxt_close_us = hwdata;
        ADDR_RATIO: nxt_ratio = hwdata[RATIO_FIELDS_W-1:0];
        ADDR_CAP: nxt_cap_reg = hwdata;
        ADDR_HOLD: nxt_hold_us = hwdata;
        ADDR_STATUS: flag_clr = wwdt_flags_t'(hwdata[ST_FLAGS_LSB +: 3]);
        default: nxt_cfg = cfg_ff;
      endcase
    end
    // a fault in the same cycle as its clear is kept
    nxt_flags = (flags_ff & ~flag_clr) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'h0;
      wr_addr_ff <= '0;
      hrdata_ff <= '0;
      hreadyout_ff <= 1'h1;
      hresp_ff <= 1'h0;
      cfg_ff <= CFG_RST;
      close_us_ff <= CLOSE_US_RST;
      ratio_ff <= RATIO_RST;
      cap_reg_ff <= CAP_RST;
      hold_us_ff <= HOLD_US_RST;
      flags_ff <= '0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'h1;
      hresp_ff <= 1'h0;
      cfg_ff <= nxt_cfg;
      close_us_ff <= nxt_close_us;
      ratio_ff <= nxt_ratio;
      cap_reg_ff <= nxt_cap_reg;
      hold_us_ff <= nxt_hold_us;
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign watchdog_fault_output_n = fault_n_ff;
  assign reset_output_n = reset_n_ff;

endmodule
`default_nettype wire

// [tb/wwdt_core_asserts.sv]
// checker: port-level properties of the window watchdog
`default_nettype none
module wwdt_core_asserts #(
  parameter logic [39:0] STARTUP_CYC = 40'h00_0000_00C8,
  parameter logic [39:0] OPEN_MAX_CYC = 40'h00_0000_01F4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic service_input,
  input wire logic guard_enable_pin,
  input wire logic ratio_select_low,
  input wire logic ratio_select_high,
  input wire logic supervisor_reset_n,
  input wire logic watchdog_fault_output_n,
  input wire logic reset_output_n
);
  // ==========================================================
  // helper: output variant, followed from bus writes to the configuration word
  import wwdt_pkg::*;
  wwdt_cfg_t wr_cfg;
  logic cfg_wr_ff;
  logic sep_ff;
  assign wr_cfg = wwdt_cfg_t'(hwdata[CFG_W-1:0]);
  // the write lands at the end of its data phase, as in the design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_wr_ff <= 1'b0;
      sep_ff <= CFG_RST.sep_fault;
    end else begin
      cfg_wr_ff <= hsel && hready && htrans[HTRANS_ACTIVE_BIT] && hwrite && (haddr[ADDR_W-1:0] == ADDR_CONFIG);
      if (cfg_wr_ff) begin
        sep_ff <= wr_cfg.sep_fault;
      end
    end
  end

  // ==========================================================
  // sequences
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // pins pass two sync flops and a state flop, six samples cover that lag
  sequence s_dis; !guard_enable_pin [*6]; endsequence
  sequence s_sup_low; !supervisor_reset_n [*6]; endsequence
  sequence s_sup_high; supervisor_reset_n [*6]; endsequence

  // ==========================================================
  // properties
  AST_DIS_QUIET: assert property (s_dis |-> watchdog_fault_output_n)
    else $error("fault output low while disabled");
  AST_SUP_QUIET: assert property (s_sup_low |-> watchdog_fault_output_n && !reset_output_n)
    else $error("watchdog active during supervisor reset");
  AST_SUP_RST: assert property ($fell(supervisor_reset_n) |-> ##[1:4] !reset_output_n)
    else $error("reset output missed supervisor reset");
  // on single-output variants a watchdog fault legally pulls the reset output
  AST_RST_FOLLOW: assert property (s_sup_high |-> reset_output_n || !sep_ff)
    else $error("reset output low with supervisor released");
  AST_SINGLE_QUIET: assert property (!sep_ff |-> watchdog_fault_output_n)
    else $error("fault pin driven on a single-output variant");
  AST_FAULT_HOLD: assert property ($fell(watchdog_fault_output_n) |-> !watchdog_fault_output_n [*8])
    else $error("fault output pulse too short");
  AST_SUP_REL: assert property ($rose(supervisor_reset_n) |-> watchdog_fault_output_n [*8])
    else $error("fault right after supervisor release");
  AST_EN_CLOSE: assert property ($rose(guard_enable_pin) |-> watchdog_fault_output_n [*8])
    else $error("fault right after enabling");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  AST_RD_STANDS: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
endmodule

bind wwdt_core wwdt_core_asserts #(.STARTUP_CYC(STARTUP_CYC), .OPEN_MAX_CYC(OPEN_MAX_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .service_input(service_input), .guard_enable_pin(guard_enable_pin),
  .ratio_select_low(ratio_select_low), .ratio_select_high(ratio_select_high),
  .supervisor_reset_n(supervisor_reset_n), .watchdog_fault_output_n(watchdog_fault_output_n),
  .reset_output_n(reset_output_n));
`default_nettype wire

// [tb/wwdt_host.sv]
// host model: makes falling service edges on request
`default_nettype none
module wwdt_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic kick,
  output logic service_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] low_cnt_ff;
  logic [2:0] nxt_low_cnt;
  // ==========================================================
  // service pulse
  // low for four cycles so the edge survives the sync flops
  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (kick) begin
      nxt_low_cnt = 3'h4;
    end else if (low_cnt_ff != 3'h0) begin
      nxt_low_cnt = low_cnt_ff - 3'h1;
    end
  end
  // counter register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_ff <= 3'h0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end
  // line idles high like a pulled-up pin
  assign service_input = (low_cnt_ff == 3'h0);
endmodule
`default_nettype wire

// [tb/tb.sv]
// testbench: window watchdog with host model and pin scenarios
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wwdt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, kick, rd_dp, hreadyout, hresp, service_input;
  logic guard_enable_pin, ratio_select_low, ratio_select_high, supervisor_reset_n;
  logic watchdog_fault_output_n, reset_output_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] exp_q[$];
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  logic [31:0] rv[6] = '{32'h17, 32'h2710, 32'h07C0E03, 32'h0, 32'h30D40, 32'h0};
  int n_fail, total_checks, cyc, n;

  // short startup and clamp counts keep the run brief
  wwdt_core #(.STARTUP_CYC(40'h00_0000_00C8), .OPEN_MAX_CYC(40'h00_0000_01F4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .service_input(service_input), .guard_enable_pin(guard_enable_pin),
    .ratio_select_low(ratio_select_low), .ratio_select_high(ratio_select_high),
    .supervisor_reset_n(supervisor_reset_n), .watchdog_fault_output_n(watchdog_fault_output_n),
    .reset_output_n(reset_output_n));
  wwdt_host i_host (.hclk(hclk), .hresetn(hresetn), .kick(kick), .service_input(service_input));

  // ==========================================================
  // clock, checks, verdict
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hung wait ends the run as a failure
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  // read data stands at the edge ending the data phase; oldest note is compared
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      check("read data", hrdata & exp_q[0][31:0], exp_q[0][63:32] & exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    rd_dp <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  // ==========================================================
  // bus and pin tasks, all entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    if (!w) exp_q.push_back({d, m});
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  // status: phase [6:4], fault and reset [2:1], sticky flags [10:8]
  task automatic st(input logic [31:0] e);
    bus(1'b0, ADDR_STATUS, e, 32'h0000_0776);
  endtask
  task automatic clr;
    bus(1'b1, ADDR_STATUS, 32'h0000_0700, 32'h0);
  endtask
  task automatic svc;
    kick <= 1'b1;
    @(posedge hclk);
    kick <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic wait_pin(input logic v, input int lim, input logic rst = 1'b0);
    n = 0;
    while ((rst ? reset_output_n : watchdog_fault_output_n) !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // ==========================================================
  // main sequence: close window 125 cycles, slot0 open 250
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    kick = 1'b0;
    rd_dp = 1'b0;
    guard_enable_pin = 1'b1;
    ratio_select_low = 1'b0;
    ratio_select_high = 1'b0;
    supervisor_reset_n = 1'b0;
    void'($urandom(29));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) bus(1'b0, ra[i], rv[i], 32'hFFFF_FFFF);
    st(32'h004);
    bus(1'b1, ADDR_CLOSE, 32'h1, 32'h0);
    bus(1'b1, ADDR_HOLD, 32'h1, 32'h0);
    supervisor_reset_n <= 1'b1;
    repeat (8) @(posedge hclk);
    st(32'h020);
    repeat ($urandom_range(5, 100)) @(posedge hclk);
    svc();
    repeat (8) @(posedge hclk);
    st(32'h030);
    repeat (20) @(posedge hclk);
    svc();
    wait_pin(1'b0, 20);
    st(32'h152);
    clr();
    wait_pin(1'b1, 200);
    repeat (5) @(posedge hclk);
    st(32'h020);
    svc();
    repeat (125 + $urandom_range(20, 220)) @(posedge hclk);
    svc();
    wait_pin(1'b0, 420);
    check("late time", 32'(n >= 365 && n <= 390), 32'h1);
    st(32'h252);
    clr();
    ratio_select_high <= 1'b1;
    ratio_select_low <= 1'b1;
    wait_pin(1'b1, 200);
    wait_pin(1'b0, 300);
    check("startup time", 32'(n >= 195 && n <= 215), 32'h1);
    st(32'h452);
    clr();
    wait_pin(1'b1, 200);
    svc();
    wait_pin(1'b0, 700);
    check("clamped time", 32'(n >= 615 && n <= 645), 32'h1);
    clr();
    wait_pin(1'b1, 200);
    svc();
    repeat (8) @(posedge hclk);
    ratio_select_high <= 1'b0;
    repeat (8) @(posedge hclk);
    st(32'h030);
    guard_enable_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    st(32'h010);
    guard_enable_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    st(32'h030);
    supervisor_reset_n <= 1'b0;
    repeat (8) @(posedge hclk);
    st(32'h004);
    supervisor_reset_n <= 1'b1;
    repeat (8) @(posedge hclk);
    st(32'h020);
    bus(1'b1, ADDR_CONFIG, 32'h16, 32'h0);
    repeat (8) @(posedge hclk);
    st(32'h010);
    ratio_select_low <= 1'b0;
    repeat (8) @(posedge hclk);
    st(32'h030);
    // single pin, single output, no startup delay; slot1 ratio set to 2
    bus(1'b1, ADDR_CONFIG, 32'h01, 32'h0);
    bus(1'b1, ADDR_RATIO, 32'h07C0403, 32'h0);
    ratio_select_low <= 1'b1;
    repeat (8) @(posedge hclk);
    svc();
    repeat (8) @(posedge hclk);
    st(32'h154);
    check("fault pin", 32'(watchdog_fault_output_n), 32'h1);
    clr();
    wait_pin(1'b1, 200, 1'b1);
    wait_pin(1'b0, 400, 1'b1);
    check("single pin time", 32'(n >= 240 && n <= 260), 32'h1);
    // capacitor mode: grounded capacitor disables, a new value waits for release
    clr();
    ratio_select_high <= 1'b1;
    bus(1'b1, ADDR_CONFIG, 32'h0B, 32'h0);
    repeat (8) @(posedge hclk);
    st(32'h010);
    bus(1'b1, ADDR_CAP, 32'h1, 32'h0);
    repeat (8) @(posedge hclk);
    st(32'h010);
    supervisor_reset_n <= 1'b0;
    repeat (8) @(posedge hclk);
    supervisor_reset_n <= 1'b1;
    wait_pin(1'b1, 20, 1'b1);
    // one unit at the fastest factor: 12375 close cycles, then the clamped open window
    wait_pin(1'b0, 13000, 1'b1);
    check("cap close time", 32'(n >= 12860 && n <= 12890), 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
